// ---- logic/torque_guard.v ----
// Safe torque off supervisor with Avalon-MM register access
//
// Operation
// - Monitor high only while both inputs low
// - Both inputs low enters torque-off state
// - Motor power removed within 15 ms
// - One input low also trips, monitor low
// - Torque-off, servo off, inputs high: drive-ready
// - Drive-ready plus servo-on gives servo-ready
// - Servo-on during torque-off latches the state
// - Latched: servo off then on recovers
// - Inputs apart over 10 s raise skew alarm
// - Own hardware fault raises separate alarm
// - Skew alarm leaves torque-off working normally
// - Drive-ready output low in torque-off state
// - Drive-ready high: inputs high, servo off
// - Torque-off drops brake output, ignores delay
// - Torque-off stops motor by stop method
// - Test pulses of two cycles or more on inputs are not filtered
// - No re-energize after drop until power cycle
// - Trip cleared only by power cycle
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`include "torque_guard_map.vh"
module torque_guard
#(
  // Skew alarm time in cycles
  parameter [63:0] SKEW_CYCLES = `TG_SKEW_S * `TG_CLK_HZ,
  // Longest power-off time in cycles, rounded down
  parameter [63:0] POWER_OFF_CYCLES = `TG_POWER_OFF_MS * `TG_CLK_HZ / 64'd1000
)
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_safe_in_a,
  input wire i_safe_in_b,
  input wire i_servo_on,
  input wire i_power_fb,
  input wire i_motor_stopped,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg o_power_enable,
  output reg o_torque_off_monitor_out,
  output reg o_drive_ready,
  output reg o_brake_control_out,
  output reg o_dyn_brake,
  output reg o_alarm_input_skew,
  output reg o_alarm_safety_hw_fault
);

  ////////////////////////////////////////////////////////////////////////
  // States, one-hot
  localparam [2:0] ST_TORQUE_OFF = 3'h1;
  localparam [2:0] ST_DRIVE_READY = 3'h2;
  localparam [2:0] ST_SERVO_READY = 3'h4;

  // Synchronised pins
  wire safe_in_a; // Safety input A
  wire safe_in_b; // Safety input B
  wire servo_on_pin; // Servo-on from the host
  wire power_fb; // Power stage feedback

  // Control registers
  reg [1:0] stop_method_param; // Stop method for servo off
  reg servo_on_mapping_param; // Servo-on forced active
  reg [15:0] brake_off_delay_param; // Brake to servo-off delay

  // Sequencer state
  reg [2:0] state; // Torque-off / drive-ready / servo-ready
  reg [2:0] next_state;
  reg son_latch; // Servo-on seen during torque-off
  reg next_son_latch;
  reg armed; // Both inputs seen high since reset
  reg trip; // Trip held until power cycle
  reg next_trip;
  reg [15:0] brake_cnt; // Normal servo-off delay count
  reg [15:0] next_brake_cnt;
  reg next_power; // Next motor power enable
  reg next_dyn; // Next dynamic brake command

  // Derived levels
  wire servo_on; // Servo-on after mapping
  wire both_high; // Both safety inputs energized
  wire skew_expired; // Inputs apart too long
  wire fault_expired; // Power stage still on too long
  wire bus_req; // Bus access pending
  wire bus_ack; // Access completes this edge
  wire [31:0] status_word; // Status register image

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  pin_sync u_sync_a
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_safe_in_a),
    .o_level(safe_in_a)
  );

  pin_sync u_sync_b
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_safe_in_b),
    .o_level(safe_in_b)
  );

  pin_sync u_sync_son
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_servo_on),
    .o_level(servo_on_pin)
  );

  pin_sync u_sync_fb
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_power_fb),
    .o_level(power_fb)
  );

  // Forced mapping would make the latched state permanent
  assign servo_on = servo_on_mapping_param | servo_on_pin;
  // Torque needs both inputs energized
  assign both_high = safe_in_a & safe_in_b;

  ////////////////////////////////////////////////////////////////////////
  // Timers for skew and hardware fault
  run_timer u_skew_timer
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(safe_in_a != safe_in_b),
    .i_limit(SKEW_CYCLES[31:0]),
    .o_expired(skew_expired)
  );

  // Power stage must follow a removal within the off time
  run_timer u_fault_timer
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(!o_power_enable && power_fb),
    .i_limit(POWER_OFF_CYCLES[31:0]),
    .o_expired(fault_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state of the sequencer
  always @*
  begin
    next_state = state;
    next_son_latch = son_latch;
    if (!both_high)
    begin
      // Either input low trips torque-off
      next_state = ST_TORQUE_OFF;
      if (servo_on)
      begin
        next_son_latch = 1'b1;
      end
    end
    else
    begin
      case (state)
        ST_TORQUE_OFF:
        begin
          // Leave only with servo off, latched or not
          if (!servo_on)
          begin
            next_state = ST_DRIVE_READY;
            next_son_latch = 1'b0;
          end
        end
        ST_DRIVE_READY:
        begin
          // Servo-on moves to servo-ready
          if (servo_on)
          begin
            next_state = ST_SERVO_READY;
          end
        end
        ST_SERVO_READY:
        begin
          // Servo off returns to drive-ready
          if (!servo_on)
          begin
            next_state = ST_DRIVE_READY;
          end
        end
        default:
        begin
          next_state = ST_TORQUE_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trip, brake delay, power and dynamic brake decisions
  always @*
  begin
    // Trip holds until reset; skew alarm does not feed it
    next_trip = trip | (armed & !both_high) | o_alarm_safety_hw_fault;
    // Delay count only on a normal servo off
    if (next_state == ST_TORQUE_OFF)
    begin
      next_brake_cnt = 16'h0;
    end
    else if (state == ST_SERVO_READY && next_state == ST_DRIVE_READY)
    begin
      next_brake_cnt = brake_off_delay_param;
    end
    else if (brake_cnt != 16'h0)
    begin
      next_brake_cnt = brake_cnt - 16'h1;
    end
    else
    begin
      next_brake_cnt = brake_cnt;
    end
    // Power only in servo-ready or the normal off delay
    next_power = !next_trip && ((next_state == ST_SERVO_READY) ||
      (next_state == ST_DRIVE_READY && next_brake_cnt != 16'h0));
    // Stopping method once power is gone
    case (stop_method_param)
      `TG_STOP_DB_HOLD:
      begin
        next_dyn = !next_power;
      end
      `TG_STOP_DB_FREE:
      begin
        next_dyn = !next_power && !i_motor_stopped;
      end
      default:
      begin
        next_dyn = 1'b0; // Coast
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and output registers
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      state <= ST_TORQUE_OFF;
      son_latch <= 1'b0;
      armed <= 1'b0;
      trip <= 1'b0;
      brake_cnt <= 16'h0;
      o_power_enable <= 1'b0;
      o_torque_off_monitor_out <= 1'b0;
      o_drive_ready <= 1'b0;
      o_brake_control_out <= 1'b0;
      o_dyn_brake <= 1'b0;
      o_alarm_input_skew <= 1'b0;
      o_alarm_safety_hw_fault <= 1'b0;
    end
    else
    begin
      state <= next_state;
      son_latch <= next_son_latch;
      armed <= armed | both_high;
      trip <= next_trip;
      brake_cnt <= next_brake_cnt;
      o_power_enable <= next_power;
      // Monitor only for both inputs low
      o_torque_off_monitor_out <= !safe_in_a && !safe_in_b;
      // Drive ready outside torque-off only
      o_drive_ready <= (next_state != ST_TORQUE_OFF);
      // Brake released only in servo-ready with power
      o_brake_control_out <= (next_state == ST_SERVO_READY) && !next_trip;
      o_dyn_brake <= next_dyn;
      // Sticky alarms, cleared by power cycle only
      o_alarm_input_skew <= o_alarm_input_skew | skew_expired;
      o_alarm_safety_hw_fault <= o_alarm_safety_hw_fault | fault_expired;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status image
  assign status_word = {20'h0,
    o_power_enable,
    son_latch,
    trip,
    o_alarm_safety_hw_fault,
    o_alarm_input_skew,
    o_torque_off_monitor_out,
    servo_on,
    safe_in_b,
    safe_in_a,
    state[2],
    state[1],
    state[0]};

  // Bus request and completion
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_ack = bus_req & !o_avs_waitrequest;

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then completion
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
      stop_method_param <= `TG_CTRL_RESET;
      servo_on_mapping_param <= 1'b0;
      brake_off_delay_param <= `TG_BRAKE_DLY_RESET;
    end
    else
    begin
      // Drop waitrequest for one cycle per access
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
      begin
        // Read data captured ahead of completion
        case (i_avs_address)
          `TG_CTRL_OFS:
          begin
            o_avs_readdata <= {29'h0, servo_on_mapping_param, stop_method_param};
          end
          `TG_BRAKE_DLY_OFS:
          begin
            o_avs_readdata <= {16'h0, brake_off_delay_param};
          end
          `TG_STATUS_OFS:
          begin
            o_avs_readdata <= status_word;
          end
          default:
          begin
            o_avs_readdata <= 32'h0; // Unmapped reads zero
          end
        endcase
      end
      if (bus_ack && i_avs_write)
      begin
        // Writes take effect at completion; others ignored
        case (i_avs_address)
          `TG_CTRL_OFS:
          begin
            stop_method_param <= i_avs_writedata[`TG_CTRL_STOP_MSB:`TG_CTRL_STOP_LSB];
            servo_on_mapping_param <= i_avs_writedata[`TG_CTRL_SON_MAP];
          end
          `TG_BRAKE_DLY_OFS:
          begin
            brake_off_delay_param <= i_avs_writedata[`TG_BRAKE_DLY_W-1:0];
          end
          default:
          begin
            stop_method_param <= stop_method_param;
          end
        endcase
      end
    end
  end

endmodule // torque_guard

// ---- logic/torque_guard_map.vh ----
// Register offsets, field positions and timing constants of the torque guard
`ifndef TORQUE_GUARD_MAP_VH
`define TORQUE_GUARD_MAP_VH

// Clock rate in Hz, wide enough for long products
`define TG_CLK_HZ 64'd250000000

// Longest time from both inputs low to motor power removed, in ms
`define TG_POWER_OFF_MS 64'd15
// Longest skew allowed between the two safety inputs, in s
`define TG_SKEW_S 64'd10

// Register byte offsets
`define TG_CTRL_OFS 4'h0
`define TG_BRAKE_DLY_OFS 4'h4
`define TG_STATUS_OFS 4'h8

// Control register fields
`define TG_CTRL_STOP_LSB 0
`define TG_CTRL_STOP_MSB 1
`define TG_CTRL_SON_MAP 2
`define TG_CTRL_RESET 2'h0

// Brake delay register width and reset value
`define TG_BRAKE_DLY_W 16
`define TG_BRAKE_DLY_RESET 16'h0000

// Stop method encodings
`define TG_STOP_DB_HOLD 2'h0
`define TG_STOP_DB_FREE 2'h1
`define TG_STOP_COAST 2'h2

// Status register bit positions
`define TG_ST_TORQUE_OFF 0
`define TG_ST_DRIVE_RDY 1
`define TG_ST_SERVO_RDY 2
`define TG_ST_IN_A 3
`define TG_ST_IN_B 4
`define TG_ST_SERVO_ON 5
`define TG_ST_MONITOR 6
`define TG_ST_SKEW 7
`define TG_ST_HW_FAULT 8
`define TG_ST_TRIP 9
`define TG_ST_SON_LATCH 10
`define TG_ST_POWER 11

`endif

// ---- logic/pin_sync.v ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_pin,
  output reg o_level
);

  reg stage1; // Metastability catcher, read by stage2 only
  reg stage2; // Second stage
  reg stage3; // Third stage

  ////////////////////////////////////////////////////////////////////////
  // Shift chain; pulses of two cycles or more pass through, single-cycle pulses are dropped
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      // Take the level once the last two stages agree
      if (stage2 == stage3)
      begin
        o_level <= stage3;
      end
    end
  end

endmodule // pin_sync

// ---- logic/run_timer.v ----
// Counter that flags when a condition has held for a given number of cycles
`timescale 1ns/1ns
module run_timer
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_run,
  input wire [31:0] i_limit,
  output wire o_expired
);

  reg [31:0] count; // Cycles the condition has held

  ////////////////////////////////////////////////////////////////////////
  // Count while running, stop at the limit, clear when the run ends
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      count <= 32'h0;
    end
    else if (!i_run)
    begin
      count <= 32'h0;
    end
    else if (count != i_limit)
    begin
      count <= count + 32'h1;
    end
  end

  // Expired while the run lasts and the limit is reached
  assign o_expired = i_run && (count == i_limit);

endmodule // run_timer

// ---- tb/safety_ctrl_model.sv ----
// Far-side safety controller that energizes the two safety inputs
`timescale 1ns/1ns
module safety_ctrl_model
(
  input wire i_clk,
  input wire i_cmd_a,
  input wire i_cmd_b,
  output reg o_safe_in_a = 1'h0,
  output reg o_safe_in_b = 1'h0
);
  ////////////////////////////////////////////////////////////////////////
  // Energized high allows torque; both outputs switch on one edge
  // Short test pulses pass as commanded, never stretched
  always @(posedge i_clk)
  begin
    o_safe_in_a <= i_cmd_a;
    o_safe_in_b <= i_cmd_b;
  end
endmodule // safety_ctrl_model

// ---- tb/torque_guard_checker.sv ----
// Port checker of the torque guard, bound to the design
`timescale 1ns/1ns
module torque_guard_checker
#(
  parameter [63:0] SKEW_CYCLES = 64'd50,
  parameter [63:0] POWER_OFF_CYCLES = 64'd20
)
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_safe_in_a,
  input wire i_safe_in_b,
  input wire i_servo_on,
  input wire i_power_fb,
  input wire i_motor_stopped,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire o_power_enable,
  input wire o_torque_off_monitor_out,
  input wire o_drive_ready,
  input wire o_brake_control_out,
  input wire o_dyn_brake,
  input wire o_alarm_input_skew,
  input wire o_alarm_safety_hw_fault
);
  ////////////////////////////////////////////////////////////////////////
  // Cycles the two pins have differed
  reg [63:0] diff_cnt;
  // Drive was ready since reset
  reg seen_ready;
  // Both inputs dropped after readiness
  reg tripped;
  // Skew counter and trip tracker
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      diff_cnt <= 64'h0;
      seen_ready <= 1'h0;
      tripped <= 1'h0;
    end
    else
    begin
      diff_cnt <= (i_safe_in_a != i_safe_in_b) ? diff_cnt + 64'h1 : 64'h0;
      seen_ready <= seen_ready | o_drive_ready;
      tripped <= tripped | (seen_ready & o_torque_off_monitor_out);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_monitor_both_low: assert property ((!i_safe_in_a && !i_safe_in_b)[*6] |=>
    o_torque_off_monitor_out) else $error("monitor stays low");
  a_monitor_one_high: assert property ((i_safe_in_a || i_safe_in_b)[*6] |=>
    !o_torque_off_monitor_out) else $error("monitor high with an input high");
  a_power_cut_off: assert property ((!i_safe_in_a || !i_safe_in_b)[*6] |=>
    !o_power_enable) else $error("power still on after input drop");
  a_brake_drop_off: assert property ((!i_safe_in_a || !i_safe_in_b)[*6] |=>
    !o_brake_control_out) else $error("brake still released");
  a_ready_low_off: assert property ((!i_safe_in_a && !i_safe_in_b)[*6] |=>
    !o_drive_ready) else $error("drive ready in torque off");
  a_ready_high_on: assert property ((i_safe_in_a && i_safe_in_b && !i_servo_on)[*8]
    |=> o_drive_ready) else $error("drive ready missing");
  a_trip_holds_off: assert property (tripped |-> !o_power_enable)
    else $error("power back without reset");
  a_skew_alarm_due: assert property (diff_cnt == SKEW_CYCLES + 64'd8 |=>
    o_alarm_input_skew) else $error("skew alarm missing");
  a_fault_stays_tripped: assert property (o_alarm_safety_hw_fault |=>
    o_alarm_safety_hw_fault && !o_power_enable) else $error("fault alarm lost");
  c_servo_ready: cover property (o_brake_control_out);
  c_skew: cover property ($rose(o_alarm_input_skew));
  c_trip: cover property ($rose(tripped));
endmodule // torque_guard_checker

bind torque_guard torque_guard_checker #(.SKEW_CYCLES(SKEW_CYCLES),
  .POWER_OFF_CYCLES(POWER_OFF_CYCLES)) i_checker (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_safe_in_a(i_safe_in_a), .i_safe_in_b(i_safe_in_b), .i_servo_on(i_servo_on),
  .i_power_fb(i_power_fb), .i_motor_stopped(i_motor_stopped),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_power_enable(o_power_enable),
  .o_torque_off_monitor_out(o_torque_off_monitor_out), .o_drive_ready(o_drive_ready),
  .o_brake_control_out(o_brake_control_out), .o_dyn_brake(o_dyn_brake),
  .o_alarm_input_skew(o_alarm_input_skew),
  .o_alarm_safety_hw_fault(o_alarm_safety_hw_fault));

// ---- tb/test_torque_guard.sv ----
// Self-checking bench of the torque guard
`timescale 1ns/1ns
module test_torque_guard;
  reg clk = 1'h0;
  reg resetn = 1'h0;
  reg cmd_a = 1'h0;
  reg cmd_b = 1'h0;
  reg servo_on = 1'h0;
  reg fb_stuck = 1'h0;
  reg stopped = 1'h0;
  reg power_fb = 1'h0;
  reg [3:0] addr = 4'h0;
  reg rd = 1'h0;
  reg wr = 1'h0;
  reg [31:0] wdata = 32'h0;
  reg [31:0] q;
  wire [31:0] rdata;
  wire wait_req, pwr, mon, rdy, brake, dyn, skew, hwf, safe_a, safe_b;
  integer n_errors = 0;
  integer check_count = 0;
  integer cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Safety controller model and the design
  safety_ctrl_model i_ctrl (.i_clk(clk), .i_cmd_a(cmd_a), .i_cmd_b(cmd_b),
    .o_safe_in_a(safe_a), .o_safe_in_b(safe_b));
  torque_guard #(.SKEW_CYCLES(64'd50), .POWER_OFF_CYCLES(64'd20)) i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_safe_in_a(safe_a), .i_safe_in_b(safe_b),
    .i_servo_on(servo_on), .i_power_fb(power_fb), .i_motor_stopped(stopped),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_power_enable(pwr),
    .o_torque_off_monitor_out(mon), .o_drive_ready(rdy), .o_brake_control_out(brake),
    .o_dyn_brake(dyn), .o_alarm_input_skew(skew), .o_alarm_safety_hw_fault(hwf));
  // Clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  // Power stage follows its enable unless stuck; hang ceiling
  always @(posedge clk)
  begin
    power_fb <= pwr | fb_stuck;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // Wait rising edges
  task step(input integer n);
  begin
    repeat (n) @(posedge clk);
  end
  endtask
  // One bus access held until waitrequest is seen low
  task acc(input w, input [3:0] a, input [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    // Only the bench ceiling ends a wait that never completes
    while (wait_req !== 1'h0)
    begin
      @(posedge clk);
    end
    q = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  end
  endtask
  // Power cycle, energize both inputs, then servo on
  task power_up;
  begin
    // Called on an edge, so reset is seen low for six edges
    resetn <= 1'h0;
    cmd_a <= 1'h1;
    cmd_b <= 1'h1;
    servo_on <= 1'h0;
    step(6);
    resetn <= 1'h1;
    step(12);
    servo_on <= 1'h1;
    step(12);
  end
  endtask
  // Verdict
  task results;
  begin
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Servo ready and registers
    power_up;
    chk(pwr, 1'h1);
    chk(brake, 1'h1);
    chk(mon, 1'h0);
    acc(1'h0, 4'h0, 32'h0);
    chk(q, 32'h0);
    acc(1'h0, 4'h4, 32'h0);
    chk(q, 32'h0);
    acc(1'h0, 4'h8, 32'h0);
    chk(q[2], 1'h1);
    acc(1'h0, 4'hc, 32'h0);
    chk(q, 32'h0);
    acc(1'h1, 4'h0, 32'h1);
    acc(1'h1, 4'h4, 32'hffff);
    acc(1'h0, 4'h4, 32'h0);
    chk(q, 32'hffff);
    $display("test 1 done");
    // Both inputs drop with servo on, long brake delay set
    cmd_a <= 1'h0;
    cmd_b <= 1'h0;
    step(8);
    chk(pwr, 1'h0);
    chk(brake, 1'h0);
    chk(rdy, 1'h0);
    chk(mon, 1'h1);
    chk(dyn, 1'h1);
    acc(1'h0, 4'h8, 32'h0);
    chk(q[0], 1'h1);
    stopped <= 1'h1;
    step(3);
    chk(dyn, 1'h0);
    cmd_a <= 1'h1;
    cmd_b <= 1'h1;
    step(10);
    chk(rdy, 1'h0);
    servo_on <= 1'h0;
    step(10);
    chk(rdy, 1'h1);
    servo_on <= 1'h1;
    step(10);
    acc(1'h0, 4'h8, 32'h0);
    chk(q[2], 1'h1);
    chk(pwr, 1'h0);
    $display("test 2 done");
    // One input drops, skew alarm, coast stop
    power_up;
    chk(pwr, 1'h1);
    acc(1'h1, 4'h0, 32'h2);
    cmd_a <= 1'h0;
    step(8);
    chk(pwr, 1'h0);
    chk(mon, 1'h0);
    chk(dyn, 1'h0);
    chk(skew, 1'h0);
    step(60);
    chk(skew, 1'h1);
    cmd_b <= 1'h0;
    step(8);
    chk(mon, 1'h1);
    servo_on <= 1'h0;
    cmd_a <= 1'h1;
    cmd_b <= 1'h1;
    step(10);
    chk(rdy, 1'h1);
    // Forced servo-on mapping shows as servo-on in status
    acc(1'h1, 4'h0, 32'h4);
    acc(1'h0, 4'h8, 32'h0);
    chk(q[5], 1'h1);
    $display("test 3 done");
    // Short test pulse, then stuck power stage
    power_up;
    stopped <= 1'h0;
    cmd_a <= 1'h0;
    step(4);
    cmd_a <= 1'h1;
    step(10);
    chk(pwr, 1'h0);
    chk(dyn, 1'h1);
    fb_stuck <= 1'h1;
    step(40);
    chk(hwf, 1'h1);
    $display("test 4 done");
    results;
  end
endmodule // test_torque_guard
